// ---- hw/rsl_pkg.sv ----
// Package: constants, encodings and carrier types for the RS-485 link supervisor
package rsl_pkg;
    // Clock and timing
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned SECOND_S        = 1;
    localparam int unsigned CYC_PER_SEC     = CLK_HZ * SECOND_S;
    localparam int unsigned BITS_PER_CHAR   = 11;
    // Station address
    localparam logic [7:0]  ADDR_MAX        = 8'hc7;
    localparam logic [7:0]  ADDR_ZERO       = 8'h00;
    localparam logic [7:0]  ADDR_FALLBACK   = 8'hff;
    // Register indices always writable
    localparam logic [7:0]  REG_OPEN_A      = 8'h04;
    localparam logic [7:0]  REG_OPEN_B      = 8'h05;
    // Timeout limit range in seconds
    localparam logic [6:0]  TMO_MAX         = 7'h63;
    localparam logic [6:0]  TMO_OFF         = 7'h00;
    // Baud rates, codes 0..7
    localparam int unsigned BAUD_1200       = 1200;
    localparam int unsigned BAUD_2400       = 2400;
    localparam int unsigned BAUD_4800       = 4800;
    localparam int unsigned BAUD_9600       = 9600;
    localparam int unsigned BAUD_19200      = 19200;
    localparam int unsigned BAUD_38400      = 38400;
    localparam int unsigned BAUD_57600      = 57600;
    localparam int unsigned BAUD_115200     = 115200;
    // Extra reply delay in character times, codes 0..5
    localparam logic [7:0]  DLY_STD         = 8'h00;
    localparam logic [7:0]  DLY_10C         = 8'h0a;
    localparam logic [7:0]  DLY_20C         = 8'h14;
    localparam logic [7:0]  DLY_50C         = 8'h32;
    localparam logic [7:0]  DLY_100C        = 8'h64;
    localparam logic [7:0]  DLY_200C        = 8'hc8;

    // Reply sequencer states
    typedef enum logic [2:0] {
        RSL_IDLE = 3'b001,
        RSL_WAIT = 3'b010,
        RSL_GO   = 3'b100
    } rsl_state_t;

    // Decoded request from the frame parser
    typedef struct packed {
        logic [7:0]  station;
        logic        is_write;
        logic [7:0]  reg_index;
    } rsl_req_t;

    // Configuration applied to the link
    typedef struct packed {
        logic [7:0]  station_addr;
        logic [2:0]  baud_sel;
        logic        remote_config_write_enable;
        logic [6:0]  interframe_timeout_limit;
        logic [2:0]  reply_extra_delay_select;
    } rsl_cfg_t;
endpackage : rsl_pkg

// ---- hw/rsl_tick_div.sv ----
// Divider producing one-cycle tick enables at a selectable period
`timescale 1ns/1ps
`default_nettype none
module rsl_tick_div #(
    parameter int unsigned CW = 24
) (
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          sys_rst,
    // Control
    input  wire logic          restart,
    input  wire logic [CW-1:0] period,
    // Tick
    output logic               tick
);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          tick_nxt;

    always_comb begin
        cnt_nxt  = cnt_r + 1'b1;
        tick_nxt = 1'b0;
        if (restart) begin
            cnt_nxt = '0;
        end else if (cnt_r + 1'b1 >= period) begin
            cnt_nxt  = '0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick  <= tick_nxt;
        end
    end
endmodule : rsl_tick_div
`default_nettype wire

// ---- hw/rsl_link_sup.sv ----
// RS-485 slave link configuration, address match and supervision
//
// What this block does
// - Station address configurable, values above 199 are clamped to 199
// - With address zero, frames addressed to 255 are answered instead
// - Line rate chosen from eight rates, 1200 up to 115200 bit/s
// - Remote-write enable decides whether configuration writes are accepted
// - Registers 04h and 05h stay writable regardless of that enable
// - Gap between frames above limit forces link-controlled outputs to alert
// - Gap limit 0 to 99 seconds, zero turns supervision off
// - Extra reply delay: none, 10c, 20c, 50c, 100c or 200c
// - When alert clears, analogue output returns to its scaled value
`timescale 1ns/1ps
`default_nettype none
module rsl_link_sup
    import rsl_pkg::*;
#(
    parameter int unsigned CYC_SEC = CYC_PER_SEC
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // Configuration
    input  wire rsl_cfg_t    cfg,
    // Frames from the parser
    input  wire logic        frame_end,
    input  wire rsl_req_t    req,
    // Analogue output path
    input  wire logic [15:0] ao_scaled,
    input  wire logic [15:0] alert_output_level,
    input  wire logic        ao_remote,
    // Results
    output logic             addr_match,
    output logic             write_accept,
    output logic             write_refuse,
    output logic [15:0]      bit_period,
    output logic             tx_enable,
    output logic             alert,
    output logic [15:0]      ao_value
);
    localparam int unsigned CW = 24;

    // Bit period in clocks for a rate code
    function automatic logic [15:0] baud_div(input logic [2:0] s);
        case (s)
            3'h0:    baud_div = 16'(CLK_HZ / BAUD_1200);
            3'h1:    baud_div = 16'(CLK_HZ / BAUD_2400);
            3'h2:    baud_div = 16'(CLK_HZ / BAUD_4800);
            3'h3:    baud_div = 16'(CLK_HZ / BAUD_9600);
            3'h4:    baud_div = 16'(CLK_HZ / BAUD_19200);
            3'h5:    baud_div = 16'(CLK_HZ / BAUD_38400);
            3'h6:    baud_div = 16'(CLK_HZ / BAUD_57600);
            default: baud_div = 16'(CLK_HZ / BAUD_115200);
        endcase
    endfunction : baud_div

    function automatic logic [7:0] delay_chars(input logic [2:0] s);
        case (s)
            3'h1:    delay_chars = DLY_10C;
            3'h2:    delay_chars = DLY_20C;
            3'h3:    delay_chars = DLY_50C;
            3'h4:    delay_chars = DLY_100C;
            3'h5:    delay_chars = DLY_200C;
            default: delay_chars = DLY_STD;
        endcase
    endfunction : delay_chars

    logic [7:0]  addr_eff;
    logic [6:0]  tmo_eff;
    logic [15:0] bit_div;
    logic        char_tick;
    logic        sec_tick;
    logic        open_reg;

    assign addr_eff = (cfg.station_addr > ADDR_MAX) ? ADDR_MAX
                                                    : cfg.station_addr;
    assign tmo_eff  = (cfg.interframe_timeout_limit > TMO_MAX) ? TMO_MAX
                    : cfg.interframe_timeout_limit;
    assign bit_div  = baud_div(cfg.baud_sel);
    assign open_reg = (req.reg_index == REG_OPEN_A)
                   || (req.reg_index == REG_OPEN_B);

    // Character-time tick for the reply delay
    rsl_tick_div #(.CW(CW)) u_char_div (
        .clock   (clock),
        .sys_rst (sys_rst),
        .restart (frame_end),
        .period  (CW'(bit_div) * CW'(BITS_PER_CHAR)),
        .tick    (char_tick)
    );

    // One-second tick for inter-frame supervision
    rsl_tick_div #(.CW(CW)) u_sec_div (
        .clock   (clock),
        .sys_rst (sys_rst),
        .restart (frame_end),
        .period  (CW'(CYC_SEC)),
        .tick    (sec_tick)
    );

    // Address and write gating
    logic match_nxt;
    logic acc_nxt;
    logic ref_nxt;

    always_comb begin
        if (addr_eff == ADDR_ZERO) begin
            match_nxt = frame_end && (req.station == ADDR_FALLBACK);
        end else begin
            match_nxt = frame_end && (req.station == addr_eff);
        end
        acc_nxt = match_nxt && req.is_write
               && (cfg.remote_config_write_enable || open_reg);
        ref_nxt = match_nxt && req.is_write
               && !cfg.remote_config_write_enable && !open_reg;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            addr_match   <= 1'b0;
            write_accept <= 1'b0;
            write_refuse <= 1'b0;
            bit_period   <= 16'h0000;
        end else begin
            addr_match   <= match_nxt;
            write_accept <= acc_nxt;
            write_refuse <= ref_nxt;
            bit_period   <= bit_div;
        end
    end

    // Inter-frame watchdog; seconds counted after each frame
    logic [6:0] sec_r;
    logic [6:0] sec_nxt;
    logic       alert_nxt;

    always_comb begin
        sec_nxt   = sec_r;
        alert_nxt = alert;
        if (frame_end) begin
            sec_nxt   = 7'h00;
            alert_nxt = 1'b0;
        end else if (tmo_eff == TMO_OFF) begin
            sec_nxt   = 7'h00;
            alert_nxt = 1'b0;
        end else if (sec_tick) begin
            if (sec_r >= tmo_eff) begin
                alert_nxt = 1'b1;
            end else begin
                sec_nxt = sec_r + 7'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sec_r <= 7'h00;
            alert <= 1'b0;
        end else begin
            sec_r <= sec_nxt;
            alert <= alert_nxt;
        end
    end

    // Alert level only overrides an output under link control
    logic [15:0] ao_nxt;

    always_comb begin
        if (alert_nxt && ao_remote) begin
            ao_nxt = alert_output_level;
        end else begin
            ao_nxt = ao_scaled;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ao_value <= 16'h0000;
        end else begin
            ao_value <= ao_nxt;
        end
    end

    // Reply wait in characters; frames during a wait do not restart it
    rsl_state_t st_r;
    rsl_state_t st_nxt;
    logic [7:0] chr_r;
    logic [7:0] chr_nxt;
    logic       txe_nxt;

    always_comb begin
        st_nxt  = st_r;
        chr_nxt = chr_r;
        txe_nxt = 1'b0;
        case (st_r)
            RSL_IDLE: begin
                if (match_nxt) begin
                    chr_nxt = delay_chars(cfg.reply_extra_delay_select);
                    st_nxt  = RSL_WAIT;
                end
            end
            RSL_WAIT: begin
                if (chr_r == DLY_STD) begin
                    st_nxt = RSL_GO;
                end else if (char_tick) begin
                    chr_nxt = chr_r - 8'h01;
                end
            end
            RSL_GO: begin
                txe_nxt = 1'b1;
                st_nxt  = RSL_IDLE;
            end
            default: begin
                st_nxt = RSL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_r      <= RSL_IDLE;
            chr_r     <= 8'h00;
            tx_enable <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            chr_r     <= chr_nxt;
            tx_enable <= txe_nxt;
        end
    end

    // Checks
    property p_fallback;
        @(posedge clock) disable iff (sys_rst)
        (frame_end && addr_eff == ADDR_ZERO && req.station == ADDR_ZERO)
            |=> !addr_match;
    endproperty
    a_fallback: assert property (p_fallback) else $error("zero matched");

    property p_bcast;
        @(posedge clock) disable iff (sys_rst)
        (frame_end && addr_eff == ADDR_ZERO && req.station == ADDR_FALLBACK)
            |=> addr_match;
    endproperty
    a_bcast: assert property (p_bcast) else $error("255 not matched");

    property p_addr_cap;
        @(posedge clock) disable iff (sys_rst)
        (frame_end && cfg.station_addr > ADDR_MAX && req.station == ADDR_MAX)
            |=> addr_match;
    endproperty
    a_addr_cap: assert property (p_addr_cap) else $error("cap no match");

    property p_refuse;
        @(posedge clock) disable iff (sys_rst)
        write_refuse |-> !write_accept && !$past(cfg.remote_config_write_enable);
    endproperty
    a_refuse: assert property (p_refuse) else $error("bad refuse");

    property p_open;
        @(posedge clock) disable iff (sys_rst)
        (match_nxt && req.is_write && open_reg) |=> write_accept;
    endproperty
    a_open: assert property (p_open) else $error("04h/05h refused");

    property p_off;
        @(posedge clock) disable iff (sys_rst)
        (tmo_eff == TMO_OFF) [*2] |-> !alert;
    endproperty
    a_off: assert property (p_off) else $error("alert while off");

    property p_alert_ao;
        @(posedge clock) disable iff (sys_rst)
        (alert && $past(ao_remote)) |-> ao_value == $past(alert_output_level);
    endproperty
    a_alert_ao: assert property (p_alert_ao) else $error("ao not alert");

    property p_restore;
        @(posedge clock) disable iff (sys_rst)
        (!alert && !$past(sys_rst)) |-> ao_value == $past(ao_scaled);
    endproperty
    a_restore: assert property (p_restore) else $error("ao stuck");

    property p_std;
        @(posedge clock) disable iff (sys_rst)
        (st_r == RSL_IDLE && match_nxt && cfg.reply_extra_delay_select == 3'h0)
            |-> ##3 tx_enable;
    endproperty
    a_std: assert property (p_std) else $error("std reply late");

    property p_frame_clear;
        @(posedge clock) disable iff (sys_rst) frame_end |=> !alert;
    endproperty
    a_frame_clear: assert property (p_frame_clear) else $error("no clear");

    c_alert: cover property (@(posedge clock) disable iff (sys_rst) $rose(alert));
    c_refuse: cover property (@(posedge clock) disable iff (sys_rst) write_refuse);
    c_tx: cover property (@(posedge clock) disable iff (sys_rst) tx_enable);
endmodule : rsl_link_sup
`default_nettype wire

// ---- sim/rsl_master_model.sv ----
// Modbus master stand-in that sends request frames to the link supervisor
`timescale 1ns/1ps
`default_nettype none
module rsl_master_model
    import rsl_pkg::*;
(
    // Clock
    input  wire logic       clock,
    // Line rate in use
    input  wire logic [2:0] baud_sel,
    // Frame to the device
    output logic            frame_end,
    output rsl_req_t        req,
    // Reply delay the master should configure
    output logic [2:0]      rec_dly
);
    initial begin
        frame_end = 1'b0;
        req = '0;
    end
    // Weak converters need extra delay only at the fast rates
    always_comb begin
        case (baud_sel)
            3'h5: rec_dly = 3'h1;
            3'h6: rec_dly = 3'h2;
            3'h7: rec_dly = 3'h3;
            default: rec_dly = 3'h0;
        endcase
    end
    task automatic send(logic [7:0] st, logic w, logic [7:0] ix);
        @(negedge clock);
        frame_end = 1'b1;
        req = '{station: st, is_write: w, reg_index: ix};
        @(negedge clock);
        frame_end = 1'b0;
        // Request no longer valid: show a changed pattern, not stale data
        req = ~req;
    endtask : send
endmodule : rsl_master_model
`default_nettype wire

// ---- sim/test_rsl_link_sup.sv ----
// Self-checking testbench for the RS-485 link supervisor
`timescale 1ns/1ps
`default_nettype none
module test_rsl_link_sup;
    import rsl_pkg::*;
    localparam int unsigned RATE[8] = '{BAUD_1200, BAUD_2400, BAUD_4800,
        BAUD_9600, BAUD_19200, BAUD_38400, BAUD_57600, BAUD_115200};
    localparam int unsigned DCH[8] = '{0, 10, 20, 50, 100, 200, 0, 0};
    localparam logic [2:0]  RB[4]  = '{3'h0, 3'h3, 3'h5, 3'h7};
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    rsl_cfg_t    cfg = '0;
    rsl_req_t    req;
    logic        frame_end, addr_match, write_accept, write_refuse;
    logic        tx_enable, alert;
    logic [15:0] ao_scaled = 16'h0000;
    logic [15:0] alert_output_level = 16'h0000;
    logic [15:0] bit_period, ao_value;
    logic        ao_remote = 1'b0;
    logic [2:0]  rec_dly;
    logic [7:0]  a, s, ix;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          n, lo;
    always #50 clock = ~clock;
    rsl_master_model rsl_master_model_inst (.clock(clock),
        .baud_sel(cfg.baud_sel), .frame_end(frame_end), .req(req),
        .rec_dly(rec_dly));
    rsl_link_sup #(.CYC_SEC(100)) rsl_link_sup_inst (.clock(clock),
        .sys_rst(sys_rst), .cfg(cfg), .frame_end(frame_end), .req(req),
        .ao_scaled(ao_scaled), .alert_output_level(alert_output_level),
        .ao_remote(ao_remote), .addr_match(addr_match),
        .write_accept(write_accept), .write_refuse(write_refuse),
        .bit_period(bit_period), .tx_enable(tx_enable), .alert(alert),
        .ao_value(ao_value));
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    function automatic logic [7:0] clampa(logic [7:0] v);
        return (v > ADDR_MAX) ? ADDR_MAX : v;
    endfunction : clampa
    function automatic logic exp_match(logic [7:0] v, logic [7:0] st);
        return (clampa(v) == ADDR_ZERO) ? (st == ADDR_FALLBACK)
                                        : (st == clampa(v));
    endfunction : exp_match
    // Sends one frame and checks the decode pulses while they stand
    task automatic frame_chk(logic [7:0] st, logic w, logic [7:0] x);
        logic m;
        logic ac;
        m = exp_match(cfg.station_addr, st);
        ac = m & w & (cfg.remote_config_write_enable | x == REG_OPEN_A
                      | x == REG_OPEN_B);
        rsl_master_model_inst.send(st, w, x);
        check("addr_match", addr_match, m);
        check("write_accept", write_accept, ac);
        check("write_refuse", write_refuse, m & w & ~ac);
    endtask : frame_chk
    initial begin
        #(100 * 95000);
        n_fail++;
        end_sim();
    end
    initial begin
        void'($urandom(59281));
        repeat (12) @(negedge clock);
        sys_rst = 1'b0;
        for (int i = 0; i < 48; i++) begin
            a = (i % 4 == 0) ? 8'h00 : (i % 4 == 1) ? 8'hc8 : 8'($urandom);
            cfg.station_addr = a;
            cfg.remote_config_write_enable = 1'($urandom);
            n = $urandom % 3;
            s = (n == 0) ? ADDR_FALLBACK : (n == 1) ? clampa(a)
                                                    : 8'($urandom);
            n = $urandom % 3;
            ix = (n == 0) ? REG_OPEN_A : (n == 1) ? REG_OPEN_B : 8'($urandom);
            frame_chk(s, 1'($urandom), ix);
            // Let the short reply wait finish before the next frame
            repeat (4) @(negedge clock);
        end
        $display("Address and write gate test done");
        for (int b = 0; b < 8; b++) begin
            cfg.baud_sel = 3'(b);
            repeat (3) @(negedge clock);
            check("bit_period", bit_period, CLK_HZ / RATE[b]);
        end
        $display("Line rate test done");
        cfg.station_addr = 8'h11;
        for (int i = 0; i < 4; i++) begin
            cfg.baud_sel = RB[i];
            @(negedge clock);
            cfg.reply_extra_delay_select = (i == 0) ? 3'h0
                                         : (i == 1) ? 3'h6 : rec_dly;
            lo = DCH[cfg.reply_extra_delay_select] * BITS_PER_CHAR
                 * (CLK_HZ / RATE[RB[i]]);
            frame_chk(8'h11, 1'b0, 8'h00);
            n = 1;
            while (tx_enable !== 1'b1 && n < lo + 50) begin
                @(negedge clock);
                n++;
            end
            if (lo == 0) begin
                check("tx_std", n, 3);
            end else begin
                check("tx_delay", n >= lo + 1 && n <= lo + 5, 1);
            end
            @(negedge clock);
            check("tx_pulse", tx_enable, 0);
        end
        $display("Reply delay test done");
        cfg.interframe_timeout_limit = 7'h02;
        ao_remote = 1'b1;
        ao_scaled = 16'($urandom);
        alert_output_level = ~ao_scaled;
        frame_chk(8'h11, 1'b0, 8'h00);
        repeat (190) @(negedge clock);
        check("alert_early", alert, 0);
        n = 0;
        while (alert !== 1'b1 && n < 150) begin
            @(negedge clock);
            n++;
        end
        check("alert", alert, 1);
        check("ao_alert", ao_value, alert_output_level);
        frame_chk(8'h11, 1'b0, 8'h00);
        check("alert_clear", alert, 0);
        check("ao_back", ao_value, ao_scaled);
        cfg.interframe_timeout_limit = TMO_OFF;
        frame_chk(8'h11, 1'b0, 8'h00);
        repeat (400) @(negedge clock);
        check("alert_off", alert, 0);
        check("ao_off", ao_value, ao_scaled);
        $display("Watchdog test done");
        end_sim();
    end
endmodule : test_rsl_link_sup
`default_nettype wire
